// ---- verif/cqm_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "cqm_defs.svh"
module cqm_monitor (
   input  wire logic                   SYS_CLK,
   input  wire logic                   ARST_N,
   input  wire logic [`CQM_NCONN-1:0]  connection_select,
   input  wire logic [`CQM_NCONN-1:0]  queue_pointer_clear,
   input  wire logic                   cfg_wr,
   input  wire cqm_pkg::cqm_dir_t      cfg_dir,
   input  wire cqm_pkg::cqm_size_t     cfg_size,
   input  wire logic                   stat_rd,
   input  wire logic                   stat_vld,
   input  wire logic [`CQM_NCONN-1:0]  global_queue_int_status,
   input  wire logic [`CQM_NCONN-1:0]  global_queue_int_enable,
   input  wire logic                   irq
);
   logic [`CQM_NCONN-1:0] sel_q;
   logic [`CQM_NCONN-1:0] clr_q;
   logic [`CQM_NCONN-1:0] fell_q;
   wire  [`CQM_NCONN-1:0] rose_w;
   wire                   pend_w;
   // Select edges and enabled pending interrupts
   assign rose_w = connection_select & ~sel_q;
   assign pend_w = |(global_queue_int_status & global_queue_int_enable);
   // Previous select, clear and drop history
   always_ff @(posedge SYS_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         sel_q  <= '0;
         clr_q  <= '0;
         fell_q <= '0;
      end
      else
      begin
         sel_q  <= connection_select;
         clr_q  <= queue_pointer_clear;
         fell_q <= sel_q & ~connection_select;
      end
   end
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!ARST_N);
   // Setup steps after the receive-queue write
   sequence rx_cfg_s;
      cfg_wr && cfg_dir == cqm_pkg::CQM_RXQ;
   endsequence
   sequence rest_s;
      cfg_wr && cfg_dir == cqm_pkg::CQM_TXQ ##1 |queue_pointer_clear
         ##1 |rose_w;
   endsequence
   AST_SETUP_ORDER: assert property (rx_cfg_s |=> rest_s)
      else $error("connection setup out of order");
   AST_CLR_BEFORE: assert property (|rose_w |-> (clr_q & rose_w) == rose_w)
      else $error("connection made without pointer clear");
   AST_DROP_CLR: assert property (|fell_q |-> (clr_q & fell_q) == fell_q)
      else $error("no pointer clear after disconnect");
   AST_NONZERO: assert property (cfg_wr |-> cfg_size != '0)
      else $error("zero queue size written");
   AST_STAT_ANSWER: assert property (stat_rd |=> stat_vld)
      else $error("status read not answered");
   AST_STAT_QUIET: assert property (!stat_rd |=> !stat_vld)
      else $error("status answer without read");
   AST_IRQ_HIGH: assert property (pend_w |-> irq)
      else $error("enabled status did not raise irq");
   AST_IRQ_LOW: assert property (!pend_w |-> !irq)
      else $error("irq without enabled status");
endmodule
`default_nettype wire

// ---- verif/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "cqm_defs.svh"
module tb;
   logic              sys_clk = 1'b0;
   logic              arst_n = 1'b0;
   logic [3:0]        rx_put = 4'h0, rx_take = 4'h0;
   logic [3:0]        tx_put = 4'h0, tx_take = 4'h0;
   logic [3:0]        ser_raw = 4'h0, hrx_raw = 4'h0, hclk_raw = 4'hF;
   logic [3:0]        ser_tx, hdlc_rx, hdlc_clk, conn_up;
   logic [7:0]        eth_data = 8'h00, wan_data, q_empty;
   logic              eth_valid = 1'b0, eth_ready, wan_valid;
   logic              wan_ready = 1'b0, busy, irq_seen;
   logic              cmd_go = 1'b0, cmd_drop = 1'b0, cmd_rd = 1'b0;
   logic [1:0]        cmd_conn = 2'h0, cmd_ie = 2'h0;
   cqm_pkg::cqm_dir_t cmd_rd_dir = cqm_pkg::CQM_RXQ;
   logic [7:0]        cmd_size = 8'h01;
   logic [12:0]       cmd_base = 13'h0000, cmd_high = 13'h0002;
   logic [12:0]       cmd_low = 13'h0001;
   int                fails = 0, check_count = 0, cyc = 0, n;
   cqm_if sw();
   cqm_host i_cqm_host (.SYS_CLK(sys_clk), .ARST_N(arst_n), .SW(sw.host),
      .CMD_GO(cmd_go), .CMD_DROP(cmd_drop), .CMD_CONN(cmd_conn),
      .CMD_SIZE(cmd_size), .CMD_BASE(cmd_base), .CMD_HIGH(cmd_high),
      .CMD_LOW(cmd_low), .CMD_IE(cmd_ie), .CMD_RD(cmd_rd),
      .CMD_RD_DIR(cmd_rd_dir), .BUSY(busy), .IRQ_SEEN(irq_seen));
   cqm_dev i_cqm_dev (.SYS_CLK(sys_clk), .ARST_N(arst_n), .SW(sw.dev),
      .RX_PUT(rx_put), .RX_TAKE(rx_take), .TX_PUT(tx_put),
      .TX_TAKE(tx_take), .SER_TX_RAW(ser_raw), .HDLC_RX_RAW(hrx_raw),
      .HDLC_CLK_RAW(hclk_raw), .SER_TX(ser_tx), .HDLC_RX(hdlc_rx),
      .HDLC_CLK(hdlc_clk), .CONN_UP(conn_up), .ETH_DATA(eth_data),
      .ETH_VALID(eth_valid), .ETH_READY(eth_ready), .WAN_DATA(wan_data),
      .WAN_VALID(wan_valid), .WAN_READY(wan_ready), .Q_EMPTY(q_empty));
   cqm_monitor i_cqm_monitor (.SYS_CLK(sys_clk), .ARST_N(arst_n),
      .connection_select(sw.connection_select),
      .queue_pointer_clear(sw.queue_pointer_clear), .cfg_wr(sw.cfg_wr),
      .cfg_dir(sw.cfg_dir), .cfg_size(sw.cfg_size), .stat_rd(sw.stat_rd),
      .stat_vld(sw.stat_vld),
      .global_queue_int_status(sw.global_queue_int_status),
      .global_queue_int_enable(sw.global_queue_int_enable), .irq(sw.irq));
   // 40 MHz clock
   initial
   begin
      forever #12.5 sys_clk = ~sys_clk;
   end
   // Cycle ceiling against hangs
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         fails++;
         wrap_up();
      end
   end
   task automatic tick();
      @(posedge sys_clk);
      #2;
   endtask
   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
      check_count++;
      if (g !== e)
      begin
         fails++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Wait out the host sequence and output latency
   task automatic settle();
      for (int i = 0; i < 30 && busy === 1'b1; i++)
         tick();
      repeat (4) tick();
   endtask
   task automatic hook(input int c, input logic [1:0] ie, input logic up);
      cmd_conn = c[1:0];
      cmd_base = 13'(c * 64);
      cmd_ie = ie;
      cmd_go = up;
      cmd_drop = !up;
      tick();
      cmd_go = 1'b0;
      cmd_drop = 1'b0;
      settle();
   endtask
   task automatic rd(input cqm_pkg::cqm_dir_t d, input int c,
                     input logic [1:0] e);
      cmd_rd = 1'b1;
      cmd_rd_dir = d;
      cmd_conn = c[1:0];
      tick();
      cmd_rd = 1'b0;
      for (int i = 0; i < 10 && sw.stat_vld !== 1'b1; i++)
         tick();
      chk("STAT_DATA", {6'h00, e}, {6'h00, sw.stat_data});
      tick();
   endtask
   task automatic ev(input logic tk, input cqm_pkg::cqm_dir_t d,
                     input int c, input int k);
      logic [3:0] v;
      v = 4'h1 << c;
      repeat (k)
      begin
         rx_put = (!tk && d == cqm_pkg::CQM_RXQ) ? v : 4'h0;
         tx_put = (!tk && d == cqm_pkg::CQM_TXQ) ? v : 4'h0;
         rx_take = (tk && d == cqm_pkg::CQM_RXQ) ? v : 4'h0;
         tx_take = (tk && d == cqm_pkg::CQM_TXQ) ? v : 4'h0;
         tick();
         {rx_put, tx_put, rx_take, tx_take} = 16'h0000;
         tick();
      end
      repeat (2) tick();
   endtask
   task automatic wrap_up();
      if (fails == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Main sequence
   initial
   begin
      repeat (8) @(posedge sys_clk);
      #2;
      chk("SER_TX", 8'h0F, {4'h0, ser_tx});
      chk("HDLC_CLK", 8'h00, {4'h0, hdlc_clk});
      chk("Q_EMPTY", 8'hFF, q_empty);
      arst_n = 1'b1;
      tick();
      for (int c = 0; c < 4; c++)
      begin
         hook(c, (c == 2) ? 2'h0 : 2'h3, 1'b1);
         chk("CONN_UP", 8'((1 << (c + 1)) - 1), {4'h0, conn_up});
      end
      chk("SER_TX", 8'h00, {4'h0, ser_tx});
      chk("HDLC_RX", 8'h00, {4'h0, hdlc_rx});
      chk("HDLC_CLK", 8'h0F, {4'h0, hdlc_clk});
      chk("IRQ_SEEN", 8'h00, {7'h00, irq_seen});
      ev(1'b0, cqm_pkg::CQM_TXQ, 0, 3);
      ev(1'b0, cqm_pkg::CQM_RXQ, 1, 1);
      ev(1'b0, cqm_pkg::CQM_RXQ, 2, 3);
      chk("Q_EMPTY", 8'hE9, q_empty);
      chk("INT_ST", 8'h01, {4'h0, sw.global_queue_int_status & 4'h5});
      chk("IRQ_SEEN", 8'h01, {7'h00, irq_seen});
      rd(cqm_pkg::CQM_TXQ, 0, 2'h3);
      rd(cqm_pkg::CQM_TXQ, 0, 2'h0);
      rd(cqm_pkg::CQM_RXQ, 2, 2'h3);
      rd(cqm_pkg::CQM_RXQ, 3, 2'h0);
      ev(1'b1, cqm_pkg::CQM_TXQ, 0, 3);
      rd(cqm_pkg::CQM_TXQ, 0, 2'h2);
      // Fill the stream buffer with the far side stalled
      n = 0;
      for (int k = 0; k < 20; k++)
      begin
         if (eth_ready !== 1'b1)
            break;
         eth_data = 8'(k);
         eth_valid = 1'b1;
         tick();
         n++;
      end
      eth_valid = 1'b0;
      chk("FILL", 8'h09, 8'(n));
      wan_ready = 1'b1;
      for (int k = 0; k < n; k++)
      begin
         chk("WAN_VALID", 8'h01, {7'h00, wan_valid});
         chk("WAN_DATA", 8'(k), wan_data);
         tick();
      end
      chk("WAN_VALID", 8'h00, {7'h00, wan_valid});
      ev(1'b0, cqm_pkg::CQM_TXQ, 0, 2);
      hook(0, 2'h3, 1'b0);
      chk("CONN_UP", 8'h0E, {4'h0, conn_up});
      chk("SER_TX", 8'h01, {4'h0, ser_tx});
      chk("HDLC_RX", 8'h01, {4'h0, hdlc_rx});
      chk("HDLC_CLK", 8'h0E, {4'h0, hdlc_clk});
      chk("Q_EMPTY", 8'hF9, q_empty);
      ev(1'b0, cqm_pkg::CQM_TXQ, 0, 2);
      chk("Q_EMPTY", 8'hF9, q_empty);
      wrap_up();
   end
endmodule
`default_nettype wire

// ---- verilog/cqm_defs.svh ----
`ifndef CQM_DEFS_SVH
`define CQM_DEFS_SVH
// Connection and queue geometry
`define CQM_NCONN        4
`define CQM_CW           2
`define CQM_SLOT_W       13
`define CQM_SIZE_W       8
`define CQM_SIZE_SHIFT   5
`define CQM_TOTAL_SLOTS  14'h2000
`define CQM_SLOT_BYTES   2048
`define CQM_DATA_W       8
`define CQM_FIFO_DEPTH   8
`define CQM_FIFO_AW      3
`define CQM_IDLE_ONE     1'b1
`define CQM_CLK_HOLD     1'b0
// Latched status layout
`define CQM_ST_HIGH      0
`define CQM_ST_LOW       1
`define CQM_ST_W         2
`define CQM_ZERO_SLOT    13'h0000
`define CQM_ONE_SLOT     13'h0001
`define CQM_ZERO_ST      2'h0
`endif

// ---- verilog/cqm_dev.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "cqm_defs.svh"
module cqm_dev (
   input  wire logic                      SYS_CLK,
   input  wire logic                      ARST_N,
   cqm_if.dev                             SW,
   // Slot traffic into and out of each queue (one per connection)
   input  wire logic [`CQM_NCONN-1:0]     RX_PUT,
   input  wire logic [`CQM_NCONN-1:0]     RX_TAKE,
   input  wire logic [`CQM_NCONN-1:0]     TX_PUT,
   input  wire logic [`CQM_NCONN-1:0]     TX_TAKE,
   // Serial-side data with hold-off while unconnected
   input  wire logic [`CQM_NCONN-1:0]     SER_TX_RAW,
   input  wire logic [`CQM_NCONN-1:0]     HDLC_RX_RAW,
   input  wire logic [`CQM_NCONN-1:0]     HDLC_CLK_RAW,
   output logic [`CQM_NCONN-1:0]          SER_TX,
   output logic [`CQM_NCONN-1:0]          HDLC_RX,
   output logic [`CQM_NCONN-1:0]          HDLC_CLK,
   output logic [`CQM_NCONN-1:0]          CONN_UP,
   // Byte stream into the serial side through the FIFO
   input  wire logic [`CQM_DATA_W-1:0]    ETH_DATA,
   input  wire logic                      ETH_VALID,
   output logic                           ETH_READY,
   output logic [`CQM_DATA_W-1:0]         WAN_DATA,
   output logic                           WAN_VALID,
   input  wire logic                      WAN_READY,
   output logic [`CQM_NCONN*2-1:0]        Q_EMPTY
);
   localparam int N = `CQM_NCONN;
   localparam int Q = 2 * N; // Index q: rx of conn c is c, tx is N+c
   cqm_pkg::cqm_slot_t base_q [Q];
   cqm_pkg::cqm_slot_t span_q [Q];
   cqm_pkg::cqm_slot_t high_q [Q];
   cqm_pkg::cqm_slot_t low_q  [Q];
   cqm_pkg::cqm_slot_t wr_q   [Q];
   cqm_pkg::cqm_slot_t rd_q   [Q];
   cqm_pkg::cqm_slot_t lvl_q  [Q];
   cqm_pkg::cqm_stat_t ie_q   [Q];
   cqm_pkg::cqm_stat_t lat_q  [Q];
   logic [N-1:0]       con_q;
   logic [N-1:0]       gstat_q;
   logic               irq_q;
   logic               svld_q;
   cqm_pkg::cqm_stat_t sdat_q;
   logic [Q-1:0]       put;
   logic [Q-1:0]       take;
   logic [Q-1:0]       clr;
   logic [Q-1:0]       hit_hi;
   logic [Q-1:0]       hit_lo;
   logic [Q-1:0]       rd_sel;
   logic [Q-1:0]       cfg_sel;
   logic [Q-1:0]       empty;
   logic [N-1:0]       drop;
   logic [N-1:0]       gsrc;
   logic [`CQM_CW:0]   sidx;
   logic [`CQM_CW:0]   cidx;

   // Connection edges; a drop flushes both queues together
   assign drop = con_q & ~SW.connection_select;
   assign put  = {TX_PUT & con_q, RX_PUT & con_q};
   assign take = {TX_TAKE & con_q, RX_TAKE & con_q};
   // Both directions cleared by one control
   assign clr  = {SW.queue_pointer_clear | drop,
                  SW.queue_pointer_clear | drop};
   assign sidx = (SW.stat_dir == cqm_pkg::CQM_TXQ) ?
                 {1'b1, SW.stat_conn} : {1'b0, SW.stat_conn};
   assign cidx = (SW.cfg_dir == cqm_pkg::CQM_TXQ) ?
                 {1'b1, SW.cfg_conn} : {1'b0, SW.cfg_conn};

   // Per-queue decodes and watermark events
   genvar g;
   generate
      for (g = 0; g < Q; g++)
      begin : gq
         logic [`CQM_SLOT_W-1:0] nxt;
         assign rd_sel[g]  = SW.stat_rd && (sidx == (`CQM_CW+1)'(g));
         assign cfg_sel[g] = SW.cfg_wr && (cidx == (`CQM_CW+1)'(g));
         assign nxt = lvl_q[g] + {{(`CQM_SLOT_W-1){1'b0}}, put[g]}
                      - {{(`CQM_SLOT_W-1){1'b0}}, take[g]};
         assign hit_hi[g] = (nxt > high_q[g]) && !(lvl_q[g] > high_q[g]);
         assign hit_lo[g] = (nxt < low_q[g]) != (lvl_q[g] < low_q[g]);
         assign empty[g]  = (lvl_q[g] == `CQM_ZERO_SLOT);

         // Ring pointers within the programmed region
         always_ff @(posedge SYS_CLK or negedge ARST_N)
         begin
            if (!ARST_N)
            begin
               wr_q[g]  <= `CQM_ZERO_SLOT;
               rd_q[g]  <= `CQM_ZERO_SLOT;
               lvl_q[g] <= `CQM_ZERO_SLOT;
            end
            else if (clr[g])
            begin
               wr_q[g]  <= base_q[g];
               rd_q[g]  <= base_q[g];
               lvl_q[g] <= `CQM_ZERO_SLOT;
            end
            else
            begin
               if (put[g])
                  wr_q[g] <= (wr_q[g] == base_q[g] + span_q[g]
                              - `CQM_ONE_SLOT) ? base_q[g]
                              : wr_q[g] + `CQM_ONE_SLOT;
               if (take[g])
                  rd_q[g] <= (rd_q[g] == base_q[g] + span_q[g]
                              - `CQM_ONE_SLOT) ? base_q[g]
                              : rd_q[g] + `CQM_ONE_SLOT;
               lvl_q[g] <= nxt;
            end
         end

         // Configuration, size scaled by 32 slots
         always_ff @(posedge SYS_CLK or negedge ARST_N)
         begin
            if (!ARST_N)
            begin
               base_q[g] <= `CQM_ZERO_SLOT;
               span_q[g] <= `CQM_ZERO_SLOT;
               high_q[g] <= `CQM_ZERO_SLOT;
               low_q[g]  <= `CQM_ZERO_SLOT;
               ie_q[g]   <= `CQM_ZERO_ST;
            end
            else if (cfg_sel[g])
            begin
               base_q[g] <= SW.cfg_base;
               span_q[g] <= `CQM_SLOT_W'({SW.cfg_size, 5'h00});
               high_q[g] <= SW.cfg_high;
               low_q[g]  <= SW.cfg_low;
               ie_q[g]   <= SW.cfg_ie;
            end
         end

         // Latches set regardless of enable; read clears, set wins
         always_ff @(posedge SYS_CLK or negedge ARST_N)
         begin
            if (!ARST_N)
               lat_q[g] <= `CQM_ZERO_ST;
            else
               lat_q[g] <= ({hit_lo[g], hit_hi[g]})
                           | (rd_sel[g] ? `CQM_ZERO_ST : lat_q[g]);
         end
      end
      // Global source per connection, gated per bit
      for (g = 0; g < N; g++)
      begin : gc
         assign gsrc[g] = |(lat_q[g] & ie_q[g]) | |(lat_q[N+g] & ie_q[N+g]);
      end
   endgenerate

   // Connection state, status answer and interrupt
   always_ff @(posedge SYS_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         con_q   <= '0;
         gstat_q <= '0;
         irq_q   <= 1'b0;
         svld_q  <= 1'b0;
         sdat_q  <= `CQM_ZERO_ST;
      end
      else
      begin
         con_q   <= SW.connection_select;
         gstat_q <= gsrc;
         irq_q   <= |(gsrc & SW.global_queue_int_enable);
         svld_q  <= SW.stat_rd;
         sdat_q  <= lat_q[sidx];
      end
   end

   // Serial-side hold-off while disconnected
   always_ff @(posedge SYS_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         SER_TX   <= {N{`CQM_IDLE_ONE}};
         HDLC_RX  <= {N{`CQM_IDLE_ONE}};
         HDLC_CLK <= {N{`CQM_CLK_HOLD}};
         CONN_UP  <= '0;
         Q_EMPTY  <= '1;
      end
      else
      begin
         SER_TX   <= (SER_TX_RAW & con_q) | ~con_q;
         HDLC_RX  <= (HDLC_RX_RAW & con_q) | ~con_q;
         HDLC_CLK <= HDLC_CLK_RAW & con_q;
         CONN_UP  <= con_q;
         Q_EMPTY  <= empty;
      end
   end

   assign SW.stat_vld                = svld_q;
   assign SW.stat_data               = sdat_q;
   assign SW.global_queue_int_status = gstat_q;
   assign SW.irq                     = irq_q;

   // Ethernet-to-WAN byte path, FIFO flushed when nothing is connected
   logic [`CQM_DATA_W-1:0] f_dat;
   logic                   f_vld;
   logic                   f_rdy;
   logic [`CQM_DATA_W-1:0] wd_q;
   logic                   wv_q;
   cqm_fifo #(.W(`CQM_DATA_W), .D(`CQM_FIFO_DEPTH), .A(`CQM_FIFO_AW)) u_f (
      .clk       (SYS_CLK),
      .arst_n    (ARST_N),
      .flush     (con_q == '0),
      .in_data   (ETH_DATA),
      .in_valid  (ETH_VALID),
      .in_ready  (f_rdy),
      .out_data  (f_dat),
      .out_valid (f_vld),
      .out_ready (!wv_q || WAN_READY)
   );
   assign ETH_READY = f_rdy;
   // Output stage register
   always_ff @(posedge SYS_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         wd_q <= '0;
         wv_q <= 1'b0;
      end
      else if (!wv_q || WAN_READY)
      begin
         wd_q <= f_dat;
         wv_q <= f_vld;
      end
   end
   assign WAN_DATA  = wd_q;
   assign WAN_VALID = wv_q;
endmodule
`default_nettype wire

// ---- verilog/cqm_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module cqm_fifo #(
   parameter int W = 8,
   parameter int D = 8,
   parameter int A = 3
) (
   input  wire logic         clk,
   input  wire logic         arst_n,
   input  wire logic         flush,
   input  wire logic [W-1:0] in_data,
   input  wire logic         in_valid,
   output logic              in_ready,
   output logic [W-1:0]      out_data,
   output logic              out_valid,
   input  wire logic         out_ready
);
   logic [W-1:0] mem [D];
   logic [A-1:0] wp_q;
   logic [A-1:0] rp_q;
   logic [A:0]   cnt_q;
   wire          push = in_valid && in_ready;
   wire          pop  = out_valid && out_ready;
   // Honest full and empty from occupancy
   assign in_ready  = (cnt_q != D[A:0]);
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem[rp_q];
   // Pointer and count update
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end
      else if (flush)
      begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end
      else
      begin
         if (push)
            wp_q <= (wp_q == A'(D - 1)) ? '0 : wp_q + 1'b1;
         if (pop)
            rp_q <= (rp_q == A'(D - 1)) ? '0 : rp_q + 1'b1;
         cnt_q <= cnt_q + {{A{1'b0}}, push} - {{A{1'b0}}, pop};
      end
   end
   // Storage
   always_ff @(posedge clk)
   begin
      if (push)
         mem[wp_q] <= in_data;
   end
endmodule
`default_nettype wire

// ---- verilog/cqm_host.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "cqm_defs.svh"
// Software-side end: sets up a connection in the prescribed order
module cqm_host (
   input  wire logic                  SYS_CLK,
   input  wire logic                  ARST_N,
   cqm_if.host                        SW,
   input  wire logic                  CMD_GO,
   input  wire logic                  CMD_DROP,
   input  wire logic [`CQM_CW-1:0]    CMD_CONN,
   input  wire cqm_pkg::cqm_size_t    CMD_SIZE,
   input  wire cqm_pkg::cqm_slot_t    CMD_BASE,
   input  wire cqm_pkg::cqm_slot_t    CMD_HIGH,
   input  wire cqm_pkg::cqm_slot_t    CMD_LOW,
   input  wire logic [`CQM_ST_W-1:0]  CMD_IE,
   input  wire logic                  CMD_RD,
   input  wire cqm_pkg::cqm_dir_t     CMD_RD_DIR,
   output logic                       BUSY,
   output logic                       IRQ_SEEN
);
   typedef enum logic [2:0] {CQM_IDLE, CQM_RXCFG, CQM_TXCFG, CQM_CLR,
                             CQM_CONN, CQM_DROPCLR, CQM_DCLR} cqm_hst_t;
   cqm_hst_t st_q;
   logic [`CQM_CW-1:0] c_q;
   logic [`CQM_NCONN-1:0] con_q;
   logic [`CQM_NCONN-1:0] one;
   cqm_pkg::cqm_slot_t    span;
   logic                  clr_st;
   assign one = `CQM_NCONN'(1) << c_q;
   // Slots of one queue, and the two pointer clear states
   assign span   = `CQM_SLOT_W'(CMD_SIZE) << `CQM_SIZE_SHIFT;
   assign clr_st = (st_q == CQM_CLR) || (st_q == CQM_DCLR);
   // Setup: sizes, thresholds, pointer clear, then connect
   always_ff @(posedge SYS_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         st_q  <= CQM_IDLE;
         c_q   <= '0;
         con_q <= '0;
      end
      else
      begin
         unique case (st_q)
            CQM_IDLE:
            begin
               c_q <= CMD_CONN;
               if (CMD_GO && CMD_SIZE != '0)
                  st_q <= CQM_RXCFG;
               else if (CMD_DROP)
                  st_q <= CQM_DROPCLR;
            end
            CQM_RXCFG: st_q <= CQM_TXCFG;
            CQM_TXCFG: st_q <= CQM_CLR;
            CQM_CLR: // Select rises right after the clear
            begin
               con_q <= con_q | one;
               st_q  <= CQM_CONN;
            end
            CQM_CONN:  st_q <= CQM_IDLE;
            CQM_DROPCLR: // Disconnect, then clear pointers
            begin
               con_q <= con_q & ~one;
               st_q  <= CQM_DCLR;
            end
            CQM_DCLR:  st_q <= CQM_IDLE;
         endcase
      end
   end
   assign SW.connection_select   = con_q;
   assign SW.queue_pointer_clear = clr_st ? one : '0;
   assign SW.cfg_wr    = (st_q == CQM_RXCFG) || (st_q == CQM_TXCFG);
   assign SW.cfg_dir   = (st_q == CQM_TXCFG) ? cqm_pkg::CQM_TXQ
                                             : cqm_pkg::CQM_RXQ;
   assign SW.cfg_conn  = c_q;
   assign SW.cfg_size  = CMD_SIZE;
   // Transmit region follows the receive region, no overlap
   assign SW.cfg_base  = (st_q == CQM_TXCFG) ? CMD_BASE + span : CMD_BASE;
   assign SW.cfg_high  = CMD_HIGH;
   assign SW.cfg_low   = CMD_LOW;
   assign SW.cfg_ie    = CMD_IE;
   assign SW.stat_rd   = CMD_RD;
   assign SW.stat_dir  = CMD_RD_DIR;
   assign SW.stat_conn = CMD_CONN;
   assign SW.global_queue_int_enable = '1;
   // Busy and interrupt observation
   always_ff @(posedge SYS_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         BUSY     <= 1'b0;
         IRQ_SEEN <= 1'b0;
      end
      else
      begin
         BUSY     <= (st_q != CQM_IDLE) || CMD_GO || CMD_DROP;
         IRQ_SEEN <= SW.irq;
      end
   end
endmodule
`default_nettype wire

// ---- verilog/cqm_if.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "cqm_defs.svh"
// Software control link between queue manager and its host
interface cqm_if;
   logic [`CQM_NCONN-1:0]   connection_select;
   logic [`CQM_NCONN-1:0]   queue_pointer_clear;
   logic [`CQM_CW-1:0]      cfg_conn;
   logic                    cfg_wr;
   cqm_pkg::cqm_dir_t       cfg_dir;
   cqm_pkg::cqm_size_t      cfg_size;
   cqm_pkg::cqm_slot_t      cfg_base;
   cqm_pkg::cqm_slot_t      cfg_high;
   cqm_pkg::cqm_slot_t      cfg_low;
   logic [`CQM_ST_W-1:0]    cfg_ie;
   logic                    stat_rd;
   cqm_pkg::cqm_dir_t       stat_dir;
   logic [`CQM_CW-1:0]      stat_conn;
   cqm_pkg::cqm_stat_t      stat_data;
   logic                    stat_vld;
   logic [`CQM_NCONN-1:0]   global_queue_int_status;
   logic [`CQM_NCONN-1:0]   global_queue_int_enable;
   logic                    irq;
   modport dev (input connection_select, queue_pointer_clear, cfg_conn,
      cfg_wr, cfg_dir, cfg_size, cfg_base, cfg_high, cfg_low, cfg_ie,
      stat_rd, stat_dir, stat_conn, global_queue_int_enable,
      output stat_data, stat_vld, global_queue_int_status, irq);
   modport host (output connection_select, queue_pointer_clear, cfg_conn,
      cfg_wr, cfg_dir, cfg_size, cfg_base, cfg_high, cfg_low, cfg_ie,
      stat_rd, stat_dir, stat_conn, global_queue_int_enable,
      input stat_data, stat_vld, global_queue_int_status, irq);
endinterface
`default_nettype wire

// ---- verilog/cqm_pkg.sv ----
`include "cqm_defs.svh"
package cqm_pkg;
   typedef logic [`CQM_SLOT_W-1:0] cqm_slot_t;
   typedef logic [`CQM_SIZE_W-1:0] cqm_size_t;
   typedef logic [`CQM_ST_W-1:0]   cqm_stat_t;
   typedef enum logic {CQM_RXQ, CQM_TXQ} cqm_dir_t;
endpackage
